// ---- mcn_decode.sv ----
`timescale 1ns/10ps
`include "mcn_map.svh"
module mcn_decode (
   mcn_link_if.dec lk
);
   logic [4:0] rs;
   logic [4:0] rn;
   logic [4:0] rd;

   assign rs = lk.insn[`MCN_F_RS];
   assign rn = lk.insn[`MCN_F_RN];
   assign rd = lk.insn[`MCN_F_RD];

   always_comb begin
      lk.stage = mcn_pkg::mcn_stage_e'(lk.insn[`MCN_F_OP1]); // R17
      // Foreign encodings count as undefined here
      lk.undef = !lk.feat || (lk.insn[`MCN_F_SIZE] != `MCN_SIZE_OK) // R18
                 || (lk.insn[`MCN_F_FIX] != `MCN_FIX_PAT)
                 || (lk.insn[`MCN_F_OP2] != `MCN_OP2_PAT)
                 || lk.insn[`MCN_F_B21]
                 || (lk.stage == mcn_pkg::MCN_STG_OTHER); // R17
      lk.overlap = (rs == rn) || (rs == rd) || (rn == rd) // R19
                   || (rd == `MCN_ZR) || (rs == `MCN_ZR) || (rn == `MCN_ZR);
   end
endmodule

// ---- mcn_link_if.sv ----
`timescale 1ns/10ps
interface mcn_link_if;
   logic [31:0]             insn;
   logic                    feat;
   mcn_pkg::mcn_stage_e     stage;
   logic                    undef;
   logic                    overlap;
   logic [63:0]             cnt;
   logic [63:0]             src;
   logic [63:0]             dst;
   logic                    opt_b;
   logic                    bwd_pick;
   logic [63:0]             p_cnt;
   logic [63:0]             p_src;
   logic [63:0]             p_dst;
   logic [3:0]              p_nzcv;

   modport dec (input insn, input feat, output stage, output undef, output overlap);
   modport pro (input cnt, input src, input dst, input opt_b, input bwd_pick,
                output p_cnt, output p_src, output p_dst, output p_nzcv);
   modport ctl (output insn, output feat, output cnt, output src, output dst,
                output opt_b, output bwd_pick, input stage, input undef, input overlap,
                input p_cnt, input p_src, input p_dst, input p_nzcv);
endinterface

// ---- mcn_map.svh ----
`ifndef MCN_MAP_SVH
`define MCN_MAP_SVH

// ----------------------------------------
// Register byte offsets, haddr[7:0]
// ----------------------------------------
`define MCN_CTRL        8'h00
`define MCN_STATUS      8'h04
`define MCN_INSN        8'h08
`define MCN_FLAGS       8'h0c
`define MCN_CNT_LO      8'h10
`define MCN_CNT_HI      8'h14
`define MCN_SRC_LO      8'h18
`define MCN_SRC_HI      8'h1c
`define MCN_DST_LO      8'h20
`define MCN_DST_HI      8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCN_CTRL_START  0
`define MCN_CTRL_OPTB   1
`define MCN_CTRL_BWD    2
`define MCN_CTRL_NOP    3
`define MCN_CTRL_FEAT   4
`define MCN_ST_BUSY     0
`define MCN_ST_UNDEF    1
`define MCN_ST_NOP      2
`define MCN_ST_FAULT    3
`define MCN_ST_DONE     4
`define MCN_FL_N        3
`define MCN_FL_C        1
`define MCN_F_SIZE      31:30
`define MCN_F_FIX       29:24
`define MCN_F_OP1       23:22
`define MCN_F_B21       21
`define MCN_F_RS        20:16
`define MCN_F_OP2       15:10
`define MCN_F_RN        9:5
`define MCN_F_RD        4:0

// ----------------------------------------
// Values
// ----------------------------------------
`define MCN_CTRL_RST    5'h10
`define MCN_FIX_PAT     6'h1d
`define MCN_OP2_PAT     6'h11
`define MCN_SIZE_OK     2'h0
`define MCN_ZR          5'h1f
`define MCN_SAT_VAL     64'h007f_ffff_ffff_ffff
`define MCN_NZCV_A      4'h0
`define MCN_NZCV_B_FWD  4'h2
`define MCN_NZCV_B_BWD  4'ha
`define MCN_PRO_BYTES   64'h0000_0000_0000_0010
`define MCN_MAIN_BYTES  64'h0000_0000_0000_0040
`define MCN_ALL_BYTES   64'hffff_ffff_ffff_ffff

`endif

// ---- mcn_mem_model.sv ----
`timescale 1ns/10ps
module mcn_mem_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [63:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic [3:0]  lat,
   input  wire logic        fault_en,
   input  wire logic [7:0]  fault_addr,
   output logic             mem_ack,
   output logic      [7:0]  mem_rdata,
   output logic             mem_err
);
   logic [7:0] mem [256];
   logic [3:0] wait_cnt;

   // ----------------------------------------
   // Byte store, low address bits only
   // ----------------------------------------
   // Idle read data toggles so a stale byte never looks valid
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= 8'h00;
         wait_cnt <= 4'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_err <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_cnt <= 4'h0;
      end else if (mem_req && wait_cnt == lat) begin
         mem_ack <= 1'b1;
         mem_err <= fault_en && !mem_we && mem_addr[7:0] == fault_addr;
         mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[7:0]];
         if (mem_we) begin
            mem[mem_addr[7:0]] <= mem_wdata;
         end
      end else begin
         wait_cnt <= mem_req ? wait_cnt + 4'h1 : 4'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// ---- mcn_pkg.sv ----
package mcn_pkg;
   typedef enum logic [1:0] {
      MCN_STG_PRO   = 2'h0,
      MCN_STG_MAIN  = 2'h1,
      MCN_STG_EPI   = 2'h2,
      MCN_STG_OTHER = 2'h3
   } mcn_stage_e;

   typedef enum logic [4:0] {
      MCN_IDLE  = 5'h01,
      MCN_SETUP = 5'h02,
      MCN_STEP  = 5'h04,
      MCN_RD    = 5'h08,
      MCN_WR    = 5'h10
   } mcn_state_e;
endpackage

// ---- mcn_prologue.sv ----
`timescale 1ns/10ps
`include "mcn_map.svh"
module mcn_prologue (
   mcn_link_if.pro lk
);
   logic [63:0] sat;
   logic        fwd;

   always_comb begin
      sat = (|lk.cnt[63:55]) ? `MCN_SAT_VAL : lk.cnt; // R1
      if ((lk.src > lk.dst) && ((lk.dst + sat) > lk.src)) begin
         fwd = 1'b1; // R2
      end else if ((lk.src < lk.dst) && ((lk.src + sat) > lk.dst)) begin
         fwd = 1'b0; // R3
      end else begin
         fwd = !lk.bwd_pick; // R4
      end
      lk.p_src = lk.src;
      lk.p_dst = lk.dst;
      lk.p_cnt = sat;
      if (!lk.opt_b) begin
         lk.p_nzcv = `MCN_NZCV_A; // R5
         if (fwd) begin
            lk.p_src = lk.src + sat; // R6
            lk.p_dst = lk.dst + sat; // R6
            lk.p_cnt = 64'h0 - sat; // R6
         end
      end else if (fwd) begin
         lk.p_nzcv = `MCN_NZCV_B_FWD; // R8
      end else begin
         lk.p_src = lk.src + sat; // R9
         lk.p_dst = lk.dst + sat; // R9
         lk.p_nzcv = `MCN_NZCV_B_BWD; // R9
      end
   end
endmodule

// ---- mcn_top.sv ----
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "mcn_map.svh"
// ------------------------------------------------------------
// Function
// R1: Prologue saturates count to 0x007FFFFFFFFFFFFF when any of bits 63:55 set.
// R2: Forward when source above destination and destination plus count passes source.
// R3: Backward when source below destination and source plus count passes destination.
// R4: Without overlap the direction is a free choice.
// R5: Algorithm A or B chosen; A shows carry flag cleared after prologue.
// R6: A forward: flags cleared, addresses plus count, count becomes negated.
// R7: A backward: addresses kept, count is saturated count minus bytes done.
// R8: B sets carry; forward advances addresses, shrinks count, clears N Z V.
// R9: B backward: addresses plus count minus done, count shrinks, NZV 1,0,0.
// R10: A later stages: signed count, negative means forward, addresses offset.
// R11: A positive count means backward, addresses highest minus count plus one.
// R12: A main stage writes count back in the same signed format.
// R13: Epilogue finishes the copy and leaves the count at zero.
// R14: B later stages: unsigned count, N clear means forward from lowest addresses.
// R15: B with N set copies backward from highest address plus one.
// R16: B forward writes back lowest uncopied addresses and remaining count.
// R17: Stage field 00 prologue, 01 main, 10 epilogue, else other encoding.
// R18: Undefined when feature absent or size field not 00.
// R19: Equal register fields or register 31 give undefined or no-operation.
// R20: Writes carry a non-temporal hint, reads are ordinary.
// R21: Software issues prologue, main, epilogue in order, back to back.
// R22: Prologue and main copy a chosen number of bytes each.
// R23: On a memory fault registers show completed bytes, then abort raised.
// R24: Copy in blocks within stage size, registers updated after each block.
// ------------------------------------------------------------
module mcn_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [63:0] mem_addr,
   output logic      [7:0]  mem_wdata,
   output logic             mem_nt,
   input  wire logic        mem_ack,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_err,
   output logic             undef_trap,
   output logic             abort
);
   mcn_link_if lk ();

   mcn_pkg::mcn_state_e state;
   mcn_pkg::mcn_stage_e stage_q;
   logic [4:0]          ctrl;
   logic [4:0]          status;
   logic [31:0]         insn;
   logic [3:0]          flags;
   logic [63:0]         cnt;
   logic [63:0]         src;
   logic [63:0]         dst;
   logic [63:0]         stg;
   logic                ap_wr;
   logic                ap_rd;
   logic [7:0]          ap_addr;
   logic                accept;
   logic                wr_ok;
   logic                start;
   logic                a_mode;
   logic                fwd;
   logic [63:0]         rem;
   logic [63:0]         off;
   logic                more;
   logic                step_ok;
   logic [31:0]         rd_mux;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   mcn_decode u_dec (
      .lk (lk.dec)
   );

   mcn_prologue u_pro (
      .lk (lk.pro)
   );

   assign lk.insn     = insn;
   assign lk.feat     = ctrl[`MCN_CTRL_FEAT];
   assign lk.cnt      = cnt;
   assign lk.src      = src;
   assign lk.dst      = dst;
   assign lk.opt_b    = ctrl[`MCN_CTRL_OPTB];
   assign lk.bwd_pick = ctrl[`MCN_CTRL_BWD];

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   // Registers only writable while idle, so the engine owns them mid-copy
   assign accept = hsel && hready && htrans[1];
   assign wr_ok  = ap_wr && (state == mcn_pkg::MCN_IDLE);
   assign start  = wr_ok && (ap_addr == `MCN_CTRL) && hwdata[`MCN_CTRL_START];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr   <= 1'b0;
         ap_rd   <= 1'b0;
         ap_addr <= 8'h00;
      end else begin
         ap_wr <= accept && hwrite;
         ap_rd <= accept && !hwrite;
         if (accept) begin
            ap_addr <= haddr[7:0];
         end
      end
   end

   // One wait state on reads keeps hrdata a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hresp     <= 1'b0;
         hreadyout <= !(accept && !hwrite);
         if (ap_rd) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_comb begin
      unique case (ap_addr)
         `MCN_CTRL:   rd_mux = {27'h0, ctrl};
         `MCN_STATUS: rd_mux = {27'h0, status};
         `MCN_INSN:   rd_mux = insn;
         `MCN_FLAGS:  rd_mux = {28'h0, flags};
         `MCN_CNT_LO: rd_mux = cnt[31:0];
         `MCN_CNT_HI: rd_mux = cnt[63:32];
         `MCN_SRC_LO: rd_mux = src[31:0];
         `MCN_SRC_HI: rd_mux = src[63:32];
         `MCN_DST_LO: rd_mux = dst[31:0];
         `MCN_DST_HI: rd_mux = dst[63:32];
         default:     rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `MCN_CTRL_RST;
         insn <= 32'h0000_0000;
      end else if (wr_ok) begin
         if (ap_addr == `MCN_CTRL) begin
            ctrl <= {hwdata[4:1], 1'b0};
         end
         if (ap_addr == `MCN_INSN) begin
            insn <= hwdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Copy direction and addressing
   // ------------------------------------------------------------
   always_comb begin
      a_mode = !flags[`MCN_FL_C];
      fwd    = a_mode ? cnt[63] : !flags[`MCN_FL_N]; // R10 R11 R14 R15
      rem    = (a_mode && fwd) ? (64'h0 - cnt) : cnt; // R10 R14
      if (a_mode) begin
         off = fwd ? cnt : (cnt - 64'h1); // R10 R11
      end else begin
         off = fwd ? 64'h0 : 64'hffff_ffff_ffff_ffff; // R14 R15
      end
      more = (rem != 64'h0) && (stg != 64'h0); // R22 R24
   end

   assign step_ok = (state == mcn_pkg::MCN_WR) && mem_ack && !mem_err;

   // ------------------------------------------------------------
   // Sequencer and memory port
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state     <= mcn_pkg::MCN_IDLE;
         stage_q   <= mcn_pkg::MCN_STG_PRO;
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= 64'h0;
         mem_wdata <= 8'h00;
         mem_nt    <= 1'b0;
      end else begin
         unique case (state)
            mcn_pkg::MCN_IDLE: begin
               if (start) begin
                  state <= mcn_pkg::MCN_SETUP;
               end
            end
            mcn_pkg::MCN_SETUP: begin
               stage_q <= lk.stage;
               if (lk.undef || lk.overlap) begin
                  state <= mcn_pkg::MCN_IDLE;
               end else begin
                  state <= mcn_pkg::MCN_STEP;
               end
            end
            mcn_pkg::MCN_STEP: begin
               if (more) begin
                  mem_req  <= 1'b1;
                  mem_we   <= 1'b0;
                  mem_nt   <= 1'b0; // R20
                  mem_addr <= src + off;
                  state    <= mcn_pkg::MCN_RD;
               end else begin
                  state <= mcn_pkg::MCN_IDLE;
               end
            end
            mcn_pkg::MCN_RD: begin
               if (mem_ack) begin
                  if (mem_err) begin
                     mem_req <= 1'b0;
                     state   <= mcn_pkg::MCN_IDLE; // R23
                  end else begin
                     mem_we    <= 1'b1;
                     mem_nt    <= 1'b1; // R20
                     mem_addr  <= dst + off;
                     mem_wdata <= mem_rdata;
                     state     <= mcn_pkg::MCN_WR;
                  end
               end
            end
            mcn_pkg::MCN_WR: begin
               if (mem_ack) begin
                  mem_req <= 1'b0;
                  mem_we  <= 1'b0;
                  mem_nt  <= 1'b0;
                  state   <= mem_err ? mcn_pkg::MCN_IDLE : mcn_pkg::MCN_STEP; // R23 R24
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Operand registers
   // ------------------------------------------------------------
   // Byte-sized blocks: every completed byte is visible before the next
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt   <= 64'h0;
         src   <= 64'h0;
         dst   <= 64'h0;
         flags <= 4'h0;
         stg   <= 64'h0;
      end else if (state == mcn_pkg::MCN_SETUP) begin
         unique case (lk.stage)
            mcn_pkg::MCN_STG_PRO:  stg <= `MCN_PRO_BYTES; // R22
            mcn_pkg::MCN_STG_MAIN: stg <= `MCN_MAIN_BYTES; // R22
            default:               stg <= `MCN_ALL_BYTES; // R13
         endcase
         if (!lk.undef && !lk.overlap && (lk.stage == mcn_pkg::MCN_STG_PRO)) begin
            cnt   <= lk.p_cnt; // R1 R6 R7 R8 R9
            src   <= lk.p_src;
            dst   <= lk.p_dst;
            flags <= lk.p_nzcv; // R5
         end
      end else if (step_ok) begin // R24
         stg <= stg - 64'h1;
         if (a_mode) begin
            cnt <= fwd ? (cnt + 64'h1) : (cnt - 64'h1); // R7 R12
         end else begin
            cnt <= cnt - 64'h1; // R8 R9 R16
            src <= fwd ? (src + 64'h1) : (src - 64'h1); // R15 R16
            dst <= fwd ? (dst + 64'h1) : (dst - 64'h1); // R15 R16
         end
      end else if (wr_ok) begin
         unique case (ap_addr)
            `MCN_FLAGS:  flags <= hwdata[3:0];
            `MCN_CNT_LO: cnt[31:0] <= hwdata;
            `MCN_CNT_HI: cnt[63:32] <= hwdata;
            `MCN_SRC_LO: src[31:0] <= hwdata;
            `MCN_SRC_HI: src[63:32] <= hwdata;
            `MCN_DST_LO: dst[31:0] <= hwdata;
            `MCN_DST_HI: dst[63:32] <= hwdata;
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Status and trap pulses
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status     <= 5'h00;
         undef_trap <= 1'b0;
         abort      <= 1'b0;
      end else begin
         undef_trap <= 1'b0;
         abort      <= 1'b0;
         if (start) begin
            status <= 5'h01;
         end else if (state == mcn_pkg::MCN_SETUP) begin
            if (lk.undef || (lk.overlap && !ctrl[`MCN_CTRL_NOP])) begin
               status     <= 5'h02; // R18 R19
               undef_trap <= 1'b1;
            end else if (lk.overlap) begin
               status <= 5'h14; // R19
            end
         end else if (((state == mcn_pkg::MCN_RD) || (state == mcn_pkg::MCN_WR))
                      && mem_ack && mem_err) begin
            status <= 5'h08; // R23
            abort  <= 1'b1; // R23
         end else if ((state == mcn_pkg::MCN_STEP) && !more) begin
            status <= 5'h10;
         end
      end
   end
endmodule

// ---- mcn_top_monitor.sv ----
`timescale 1ns/10ps
module mcn_top_monitor (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [63:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_nt,
   input wire logic        mem_ack,
   input wire logic [7:0]  mem_rdata,
   input wire logic        mem_err,
   input wire logic        undef_trap,
   input wire logic        abort
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ----------------------------------------
   // Memory port
   // ----------------------------------------
   property p_nt_wr; mem_req && mem_we |-> mem_nt; endproperty
   a_nt_wr: assert property (p_nt_wr) else $error("write lacks hint");
   property p_nt_rd; mem_req && !mem_we |-> !mem_nt; endproperty
   a_nt_rd: assert property (p_nt_rd) else $error("read carries hint");
   property p_hold;
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
                              && $stable(mem_wdata); endproperty
   a_hold: assert property (p_hold) else $error("request changed early");
   property p_rd_wr; mem_req && !mem_we && mem_ack && !mem_err |=> mem_req && mem_we; endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
   property p_wdata;
      mem_req && !mem_we && mem_ack && !mem_err |=> mem_wdata == $past(mem_rdata);
   endproperty
   a_wdata: assert property (p_wdata) else $error("byte differs");
   property p_gap; mem_req && mem_we && mem_ack |=> !mem_req; endproperty
   a_gap: assert property (p_gap) else $error("no idle cycle between bytes");

   // ----------------------------------------
   // Faults and traps
   // ----------------------------------------
   property p_err_stop; mem_ack && mem_err |=> !mem_req [*4]; endproperty
   a_err_stop: assert property (p_err_stop) else $error("copy went on after fault");
   property p_abort; mem_req && mem_ack && mem_err |=> ##[0:1] abort; endproperty
   a_abort: assert property (p_abort) else $error("abort missing");
   property p_undef_pulse; undef_trap |=> !undef_trap; endproperty
   a_undef_pulse: assert property (p_undef_pulse) else $error("trap too long");
   property p_undef_quiet; undef_trap |-> !mem_req; endproperty
   a_undef_quiet: assert property (p_undef_quiet) else $error("access on trap");
endmodule

bind mcn_top mcn_top_monitor mcn_top_monitor_i (
   .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_nt(mem_nt), .mem_ack(mem_ack),
   .mem_rdata(mem_rdata), .mem_err(mem_err), .undef_trap(undef_trap), .abort(abort)
);

// ---- memory_copy_nontemporal_write_tb.sv ----
`timescale 1ns/10ps
`include "mcn_map.svh"
module memory_copy_nontemporal_write_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        mem_req;
   logic        mem_we;
   logic [63:0] mem_addr;
   logic [7:0]  mem_wdata;
   logic        mem_nt;
   logic        mem_ack;
   logic [7:0]  mem_rdata;
   logic        mem_err;
   logic        undef_trap;
   logic        abort;
   logic [3:0]  lat;
   logic        fault_en;
   logic [7:0]  fault_addr;
   int          n_mismatch;
   int          checks;
   int          n_undef;
   int          n_abort;

   mcn_top mcn_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_nt(mem_nt), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .mem_err(mem_err), .undef_trap(undef_trap), .abort(abort)
   );
   mcn_mem_model mcn_mem_model_i (
      .hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .fault_en(fault_en),
      .fault_addr(fault_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_err(mem_err)
   );

   always #2.5 hclk = ~hclk;
   always @(posedge hclk) begin
      if (undef_trap === 1'b1) n_undef++;
      if (abort === 1'b1) n_abort++;
   end

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_hi;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   // Every signal moves right after an edge; data taken at the ready edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      wait_hi();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_hi();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      chk({32'h0, r}, {32'h0, exp});
   endtask
   task automatic wr64(input logic [7:0] a, input logic [63:0] v);
      logic [31:0] r;
      ahb(1'b1, a, v[31:0], r);
      ahb(1'b1, a + 8'h4, v[63:32], r);
   endtask
   task automatic setr(input logic [63:0] s, input logic [63:0] d, input logic [63:0] c);
      wr64(`MCN_SRC_LO, s);
      wr64(`MCN_DST_LO, d);
      wr64(`MCN_CNT_LO, c);
   endtask
   task automatic chkr(input logic [63:0] s, input logic [63:0] d, input logic [63:0] c,
                       input logic [3:0] f);
      logic [31:0] lo;
      logic [31:0] hi;
      ahb(1'b0, `MCN_SRC_LO, 32'h0, lo);
      ahb(1'b0, `MCN_SRC_HI, 32'h0, hi);
      chk({hi, lo}, s);
      ahb(1'b0, `MCN_DST_LO, 32'h0, lo);
      ahb(1'b0, `MCN_DST_HI, 32'h0, hi);
      chk({hi, lo}, d);
      ahb(1'b0, `MCN_CNT_LO, 32'h0, lo);
      ahb(1'b0, `MCN_CNT_HI, 32'h0, hi);
      chk({hi, lo}, c);
      rdchk(`MCN_FLAGS, {28'h0, f});
   endtask
   function automatic logic [31:0] mk(input logic [1:0] op1, input logic [4:0] rs,
                                       input logic [4:0] rn, input logic [4:0] rd);
      return {2'h0, 6'h1d, op1, 1'b0, rs, 6'h11, rn, rd};
   endfunction
   // Start one stage and poll until idle; a hang ends the run
   task automatic run(input logic [31:0] insn, input logic [31:0] ctrl, input logic [7:0] st);
      logic [31:0] r;
      int n;
      ahb(1'b1, `MCN_INSN, insn, r);
      ahb(1'b1, `MCN_CTRL, ctrl, r);
      n = 0;
      do begin
         ahb(1'b0, `MCN_STATUS, 32'h0, r);
         n++;
      end while (r[0] !== 1'b0 && n < 2000);
      if (n >= 2000) begin
         n_mismatch++;
         wrap_up();
      end
      chk({56'h0, r[7:0]}, {56'h0, st});
   endtask
   task automatic init_mem;
      for (int i = 0; i < 256; i++) begin
         mcn_mem_model_i.mem[i] = 8'(i) ^ 8'h5a;
      end
   endtask
   task automatic chkmem(input logic [7:0] d, input logic [7:0] s, input int n);
      for (int i = 0; i < n; i++) begin
         chk({56'h0, mcn_mem_model_i.mem[d + 8'(i)]}, {56'h0, (s + 8'(i)) ^ 8'h5a});
      end
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      lat = 4'h0;
      fault_en = 1'b0;
      fault_addr = 8'h00;
      n_mismatch = 0;
      checks = 0;
      n_undef = 0;
      n_abort = 0;
      init_mem();
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk(`MCN_CTRL, 32'h10);
      rdchk(`MCN_STATUS, 32'h0);
      rdchk(8'h40, 32'h0);
      run(mk(2'h0, 5'd2, 5'd3, 5'd1) | 32'h4000_0000, 32'h11, 8'h02);
      run(mk(2'h0, 5'd2, 5'd3, 5'd1), 32'h01, 8'h02);
      run(mk(2'h0, 5'd2, 5'd2, 5'd1), 32'h11, 8'h02);
      run(mk(2'h1, 5'd2, 5'd3, 5'd31), 32'h19, 8'h14);
      run(mk(2'h0, 5'd31, 5'd3, 5'd1), 32'h11, 8'h02);
      run(mk(2'h3, 5'd2, 5'd3, 5'd1), 32'h11, 8'h02);
      chk(64'(n_undef), 64'd5);
      // Overlap must win over the backward pick
      setr(64'h20, 64'h10, 64'h8000_0000_0000_0005);
      run(mk(2'h0, 5'd2, 5'd3, 5'd1), 32'h15, 8'h10);
      chkr(64'h20 + `MCN_SAT_VAL, 64'h10 + `MCN_SAT_VAL, 64'h10 - `MCN_SAT_VAL, 4'h0);
      chkmem(8'h10, 8'h20, 16);
      lat <= 4'h3;
      run(mk(2'h1, 5'd2, 5'd3, 5'd1), 32'h11, 8'h10);
      chkr(64'h20 + `MCN_SAT_VAL, 64'h10 + `MCN_SAT_VAL, 64'h50 - `MCN_SAT_VAL, 4'h0);
      init_mem();
      lat <= 4'h1;
      setr(64'h10, 64'h18, 64'h20);
      run(mk(2'h0, 5'd2, 5'd3, 5'd1), 32'h13, 8'h10);
      chkr(64'h20, 64'h28, 64'h10, 4'ha);
      run(mk(2'h2, 5'd2, 5'd3, 5'd1), 32'h11, 8'h10);
      chkr(64'h10, 64'h18, 64'h0, 4'ha);
      chkmem(8'h18, 8'h10, 32);
      // Flags preset so either flag policy on a fault reads the same
      lat <= 4'h0;
      fault_en <= 1'b1;
      fault_addr <= 8'h83;
      rdchk(`MCN_CTRL, 32'h10);
      wr64(`MCN_FLAGS, 64'h2);
      setr(64'h80, 64'hc0, 64'h8);
      run(mk(2'h0, 5'd2, 5'd3, 5'd1), 32'h13, 8'h08);
      chkr(64'h83, 64'hc3, 64'h5, 4'h2);
      chk(64'(n_abort), 64'd1);
      fault_en <= 1'b0;
      init_mem();
      setr(64'h40, 64'h60, 64'h10);
      run(mk(2'h0, 5'd2, 5'd3, 5'd1), 32'h15, 8'h10);
      chkr(64'h40, 64'h60, 64'h0, 4'h0);
      chkmem(8'h60, 8'h40, 16);
      wrap_up();
   end
endmodule
